// [rtl/sdc_pkg.sv]
// Purpose: Shared constants for the stall detection control block
// Assumes: System clock of 25 MHz
// Notes:   Command codes and field layouts of the two-wire command bus

package sdc_pkg;

	// ************************************************************
	// Bus addressing and commands
	// ************************************************************
	// Device address value is arbitrary
	localparam logic [6:0] DEV_ADDR           = 7'h60;
	localparam logic [7:0] CMD_SET_STALL      = 8'h96;
	localparam logic [7:0] CMD_SET_NV         = 8'h90;
	localparam logic [7:0] CMD_MOTION_QUALIFY = 8'h9f;
	localparam logic [3:0] MAX_WR_BYTES       = 4'h8;
	localparam logic [1:0] CMD_BYTES          = 2'h3;
	localparam logic       BUS_IDLE           = 1'b1;

	// ************************************************************
	// Parameter byte layouts
	// ************************************************************
	localparam int P1_ABS_HI    = 7;
	localparam int P1_ABS_LO    = 4;
	localparam int P1_DEL_HI    = 3;
	localparam int P1_DEL_LO    = 0;
	localparam int P2_FULL_DUTY = 6;
	localparam int P2_ACT_HI    = 5;
	localparam int P2_ACT_LO    = 3;
	localparam int P2_SMP_HI    = 2;
	localparam int P2_SMP_LO    = 0;

	// ************************************************************
	// Status byte layout
	// ************************************************************
	localparam int ST_DEL_HIGH  = 0;
	localparam int ST_DEL_LOW   = 1;
	localparam int ST_ABS       = 2;
	localparam int ST_STALL     = 3;
	localparam int ST_STEP_LOSS = 4;
	localparam int ST_MQ        = 5;

	// ************************************************************
	// Nonvolatile defaults and threshold levels
	// ************************************************************
	localparam logic [3:0]  OTP_ABS_DEFAULT = 4'h0;
	localparam logic [3:0]  OTP_DEL_DEFAULT = 4'h0;
	localparam logic [2:0]  SMP_DEFAULT     = 3'h0;
	localparam logic [2:0]  ACT_DEFAULT     = 3'h0;
	localparam logic        DUTY_DEFAULT    = 1'b0;
	localparam logic [12:0] ABS_STEP_MV     = 13'h01f4;
	localparam logic [11:0] DEL_STEP_MV     = 12'h0fa;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_SYS_MHZ     = 25;
	localparam int SAMPLE_BASE_NS  = 87000;
	localparam int SAMPLE_STEP_NS  = 43500;
	localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_NS * CLK_SYS_MHZ / 1000;
	localparam int SAMPLE_STEP_CYC = SAMPLE_STEP_NS * CLK_SYS_MHZ / 1000;

endpackage

// [rtl/sdc_sync_filter.sv]
// Purpose: Two-stage synchroniser followed by a three-sample glitch filter
// Assumes: Input is asynchronous to clk
// Notes:   Output moves only after three equal synchronised samples

module sdc_sync_filter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Line
	input  wire logic lineIn,
	output logic      lineOut
);

	logic       meta_reg;
	logic       sync_reg;
	logic [2:0] hist_reg;

	// ************************************************************
	// Synchroniser
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= sdc_pkg::BUS_IDLE;
			sync_reg <= sdc_pkg::BUS_IDLE;
		end else begin
			meta_reg <= lineIn;
			sync_reg <= meta_reg;
		end
	end

	// ************************************************************
	// Glitch filter
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			hist_reg <= {3{sdc_pkg::BUS_IDLE}};
			lineOut  <= sdc_pkg::BUS_IDLE;
		end else begin
			hist_reg <= {hist_reg[1:0], sync_reg};
			if (hist_reg == 3'h7) begin
				lineOut <= 1'b1;
			end else if (hist_reg == 3'h0) begin
				lineOut <= 1'b0;
			end
		end
	end

endmodule

// [rtl/sdc_stall_detection_control.sv]
// Purpose: Stall detection settings, stall flags and two-wire slave
// Assumes: Motion inputs come from logic on clk_sys
// Notes:   Bus lines are oversampled on clk_link
// Notes on behaviour
// - Status read returns then clears stall flags
// - Cleared flags resume positioning and position updates
// - Both thresholds zero disables motion detection
// - Stall command writes both RAM thresholds
// - Nonvolatile thresholds load into RAM at reset
// - Index zero disables; linear threshold level steps
// - Zero crossing starts delay; sample at expiry
// - Delay 87 us plus 43.5 us per code
// - Detection armed after ramp plus extra steps
// - Activation field gives extra full steps directly
// - Full duty suppresses detection unless enabled
// - Qualify command turns switch pin analog
// - Qualification mode persists until reset
// - Qualification mode blocks switch input sampling
// - Slave only; never drives clock edges
// - Byte transfers both ways up to 400 kb/s
// - Data input filtered against short glitches
// - Slave may stretch clock; master waits
// - Stall flag is OR of three flags
// - Stall while positioning: stop, flag, copy position

module sdc_stall_detection_control #(
	parameter int SAMPLE_BASE_CYC = sdc_pkg::SAMPLE_BASE_CYC,
	parameter int SAMPLE_STEP_CYC = sdc_pkg::SAMPLE_STEP_CYC
) (
	// System clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Bus side
	input  wire logic        clk_link,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	// Motion inputs
	input  wire logic        zeroCross,
	input  wire logic        accelDone,
	input  wire logic        fullStep,
	input  wire logic        dutyFull,
	input  wire logic        positioning,
	input  wire logic [15:0] internalPos,
	input  wire logic        bemfBelowAbs,
	input  wire logic        bemfBelowAvg,
	input  wire logic        bemfAboveAvg,
	input  wire logic        switchPin,
	// Settings and levels
	output logic [3:0]       absoluteThreshold,
	output logic [3:0]       deltaThreshold,
	output logic [12:0]      absLevelMv,
	output logic [11:0]      deltaLevelMv,
	// Stall results
	output logic             sampleStrobe,
	output logic             hardStop,
	output logic             positionAccept,
	output logic [15:0]      actualPosition,
	output logic             stepLossFlag,
	output logic             stallFlag,
	output logic             absStallFlag,
	output logic             delLowFlag,
	output logic             delHighFlag,
	output logic             switchState,
	output logic             swiAnalogEn
);

	typedef enum {IDLE, ADDR, ACK_ADDR, WRITE, ACK_WR, STRETCH, READ, ACK_RD, RD_NEXT} sdc_st_e;

	// ************************************************************
	// Link domain
	// ************************************************************
	logic        rstMeta_reg, linkRst_reg;
	logic        sclF, sdaF, sclPrev_reg, sdaPrev_reg;
	sdc_st_e     state_reg;
	logic [3:0]  bitCnt_reg, byteCnt_reg;
	logic [7:0]  shift_reg, txByte_reg, cmd_reg, par1_reg, par2_reg;
	logic        wrote_reg;
	logic [23:0] cmdWord_reg;
	logic        cmdTgl_reg, stReqTgl_reg;
	logic        ackMeta_reg, ackS2_reg, ackS3_reg;
	logic [7:0]  statusSnap_reg;
	logic        stAckTgl_reg;
	logic        sclRise, sclFall, busStart, busStop, commit;

	always_ff @(posedge clk_link) begin
		rstMeta_reg <= sys_rst;
		linkRst_reg <= rstMeta_reg;
	end

	sdc_sync_filter u_scl (.clk(clk_link), .rst(linkRst_reg), .lineIn(sclIn), .lineOut(sclF));
	sdc_sync_filter u_sda (.clk(clk_link), .rst(linkRst_reg), .lineIn(sdaIn), .lineOut(sdaF));

	assign sclRise  = sclF && !sclPrev_reg;
	assign sclFall  = !sclF && sclPrev_reg;
	assign busStart = sclF && sclPrev_reg && sdaPrev_reg && !sdaF;
	assign busStop  = sclF && sclPrev_reg && !sdaPrev_reg && sdaF;
	assign commit   = (busStart || busStop) && wrote_reg;

	always_ff @(posedge clk_link) begin
		if (linkRst_reg) begin
			sclPrev_reg <= sdc_pkg::BUS_IDLE;
			sdaPrev_reg <= sdc_pkg::BUS_IDLE;
			ackMeta_reg <= 1'b0;
			ackS2_reg   <= 1'b0;
			ackS3_reg   <= 1'b0;
			sdaOut      <= 1'b0;
			sclOut      <= 1'b0;
		end else begin
			sclPrev_reg <= sclF;
			sdaPrev_reg <= sdaF;
			ackMeta_reg <= stAckTgl_reg;
			ackS2_reg   <= ackMeta_reg;
			ackS3_reg   <= ackS2_reg;
			sdaOut      <= 1'b0;
			sclOut      <= 1'b0;
		end
	end

	// Command word stays put until the next frame is committed
	always_ff @(posedge clk_link) begin
		if (linkRst_reg) begin
			cmdWord_reg <= 24'h000000;
			cmdTgl_reg  <= 1'b0;
		end else if (commit) begin
			cmdWord_reg <= {cmd_reg, par1_reg, par2_reg};
			cmdTgl_reg  <= ~cmdTgl_reg;
		end
	end

	always_ff @(posedge clk_link) begin
		if (linkRst_reg) begin
			state_reg    <= IDLE;
			bitCnt_reg   <= 4'h0;
			byteCnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			txByte_reg   <= 8'h00;
			cmd_reg      <= 8'h00;
			par1_reg     <= 8'h00;
			par2_reg     <= 8'h00;
			wrote_reg    <= 1'b0;
			stReqTgl_reg <= 1'b0;
			sdaOe        <= 1'b0;
			sclOe        <= 1'b0;
		end else if (busStart || busStop) begin
			state_reg  <= busStart ? ADDR : IDLE;
			bitCnt_reg <= 4'h0;
			wrote_reg  <= 1'b0;
			sdaOe      <= 1'b0;
			sclOe      <= 1'b0;
		end else begin
			case (state_reg)
				ADDR, WRITE: begin
					if (sclRise) begin
						shift_reg  <= {shift_reg[6:0], sdaF};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (sclFall && bitCnt_reg == 4'h8) begin
						if (state_reg == ADDR) begin
							byteCnt_reg <= 4'h0;
							if (shift_reg[7:1] == sdc_pkg::DEV_ADDR) begin
								sdaOe     <= 1'b1;
								state_reg <= ACK_ADDR;
							end else begin
								state_reg <= IDLE;
							end
						end else if (byteCnt_reg < sdc_pkg::MAX_WR_BYTES) begin
							if (byteCnt_reg == 4'h0) begin
								cmd_reg <= shift_reg;
							end else if (byteCnt_reg == 4'h1) begin
								par1_reg <= shift_reg;
							end else if (byteCnt_reg == 4'h2) begin
								par2_reg <= shift_reg;
							end
							byteCnt_reg <= byteCnt_reg + 4'h1;
							wrote_reg   <= 1'b1;
							sdaOe       <= 1'b1;
							state_reg   <= ACK_WR;
						end else begin
							state_reg <= IDLE;
						end
					end
				end
				ACK_ADDR: begin
					if (sclFall) begin
						sdaOe      <= 1'b0;
						bitCnt_reg <= 4'h0;
						if (shift_reg[0]) begin
							stReqTgl_reg <= ~stReqTgl_reg;
							sclOe        <= 1'b1;
							state_reg    <= STRETCH;
						end else begin
							state_reg <= WRITE;
						end
					end
				end
				ACK_WR: begin
					if (sclFall) begin
						sdaOe      <= 1'b0;
						bitCnt_reg <= 4'h0;
						state_reg  <= WRITE;
					end
				end
				STRETCH: begin
					if (ackS2_reg != ackS3_reg) begin
						txByte_reg <= statusSnap_reg;
						sdaOe      <= !statusSnap_reg[7];
						sclOe      <= 1'b0;
						state_reg  <= READ;
					end
				end
				READ: begin
					if (sclFall) begin
						if (bitCnt_reg == 4'h7) begin
							sdaOe     <= 1'b0;
							state_reg <= ACK_RD;
						end else begin
							sdaOe      <= !txByte_reg[6];
							txByte_reg <= {txByte_reg[6:0], 1'b0};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end
					end
				end
				ACK_RD: begin
					if (sclRise) begin
						state_reg <= sdaF ? IDLE : RD_NEXT;
					end
				end
				RD_NEXT: begin
					if (sclFall) begin
						txByte_reg <= statusSnap_reg;
						sdaOe      <= !statusSnap_reg[7];
						bitCnt_reg <= 4'h0;
						state_reg  <= READ;
					end
				end
				default: begin
					state_reg <= IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// System domain: command intake
	// ************************************************************
	logic       cmdMeta_reg, cmdS2_reg, cmdS3_reg, cmdEdge;
	logic       rqMeta_reg, rqS2_reg, rqS3_reg, stReqEdge;
	logic       swMeta_reg, swSync_reg, mq_reg;
	logic [3:0] otpAbs_reg = sdc_pkg::OTP_ABS_DEFAULT;
	logic [3:0] otpDel_reg = sdc_pkg::OTP_DEL_DEFAULT;
	logic [2:0] smpSel_reg, actSel_reg;
	logic       dutyEn_reg;

	assign cmdEdge   = cmdS2_reg != cmdS3_reg;
	assign stReqEdge = rqS2_reg != rqS3_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			{cmdMeta_reg, cmdS2_reg, cmdS3_reg} <= 3'h0;
			{rqMeta_reg, rqS2_reg, rqS3_reg}    <= 3'h0;
		end else begin
			{cmdMeta_reg, cmdS2_reg, cmdS3_reg} <= {cmdTgl_reg, cmdMeta_reg, cmdS2_reg};
			{rqMeta_reg, rqS2_reg, rqS3_reg}    <= {stReqTgl_reg, rqMeta_reg, rqS2_reg};
		end
	end

	// Nonvolatile copies are kept through reset
	always_ff @(posedge clk_sys) begin
		if (!sys_rst && cmdEdge && cmdWord_reg[23:16] == sdc_pkg::CMD_SET_NV) begin
			otpAbs_reg <= cmdWord_reg[8 + sdc_pkg::P1_ABS_HI : 8 + sdc_pkg::P1_ABS_LO];
			otpDel_reg <= cmdWord_reg[8 + sdc_pkg::P1_DEL_HI : 8 + sdc_pkg::P1_DEL_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			absoluteThreshold <= otpAbs_reg;
			deltaThreshold    <= otpDel_reg;
			smpSel_reg        <= sdc_pkg::SMP_DEFAULT;
			actSel_reg        <= sdc_pkg::ACT_DEFAULT;
			dutyEn_reg        <= sdc_pkg::DUTY_DEFAULT;
		end else if (cmdEdge && cmdWord_reg[23:16] == sdc_pkg::CMD_SET_STALL) begin
			absoluteThreshold <= cmdWord_reg[8 + sdc_pkg::P1_ABS_HI : 8 + sdc_pkg::P1_ABS_LO];
			deltaThreshold    <= cmdWord_reg[8 + sdc_pkg::P1_DEL_HI : 8 + sdc_pkg::P1_DEL_LO];
			dutyEn_reg        <= cmdWord_reg[sdc_pkg::P2_FULL_DUTY];
			actSel_reg        <= cmdWord_reg[sdc_pkg::P2_ACT_HI : sdc_pkg::P2_ACT_LO];
			smpSel_reg        <= cmdWord_reg[sdc_pkg::P2_SMP_HI : sdc_pkg::P2_SMP_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			absLevelMv   <= 13'h0000;
			deltaLevelMv <= 12'h000;
		end else begin
			absLevelMv   <= 13'(absoluteThreshold * sdc_pkg::ABS_STEP_MV);
			deltaLevelMv <= 12'(deltaThreshold * sdc_pkg::DEL_STEP_MV);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mq_reg      <= 1'b0;
			swiAnalogEn <= 1'b0;
			swMeta_reg  <= 1'b0;
			swSync_reg  <= 1'b0;
			switchState <= 1'b0;
		end else begin
			if (cmdEdge && cmdWord_reg[23:16] == sdc_pkg::CMD_MOTION_QUALIFY) begin
				mq_reg <= 1'b1;
			end
			swiAnalogEn <= mq_reg;
			swMeta_reg  <= switchPin;
			swSync_reg  <= swMeta_reg;
			if (!mq_reg) begin
				switchState <= swSync_reg;
			end
		end
	end

	// ************************************************************
	// System domain: sampling and activation
	// ************************************************************
	logic        mdEnabled, detectActive, anySet, setAbs, setLow, setHigh;
	logic        delayBusy_reg, armed_reg;
	logic [13:0] delayCnt_reg, delayLoad;
	logic [2:0]  stepCnt_reg;

	assign mdEnabled    = (absoluteThreshold != 4'h0) || (deltaThreshold != 4'h0);
	assign detectActive = mdEnabled && armed_reg && (!dutyFull || dutyEn_reg);
	assign delayLoad    = 14'(SAMPLE_BASE_CYC) + 14'(14'(smpSel_reg) * 14'(SAMPLE_STEP_CYC));

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			delayBusy_reg <= 1'b0;
			delayCnt_reg  <= 14'h0000;
			sampleStrobe  <= 1'b0;
		end else begin
			sampleStrobe <= 1'b0;
			if (!mdEnabled) begin
				delayBusy_reg <= 1'b0;
			end else if (zeroCross) begin
				delayBusy_reg <= 1'b1;
				delayCnt_reg  <= delayLoad;
			end else if (delayBusy_reg) begin
				if (delayCnt_reg <= 14'h0001) begin
					delayBusy_reg <= 1'b0;
					sampleStrobe  <= 1'b1;
				end else begin
					delayCnt_reg <= delayCnt_reg - 14'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !accelDone || !positioning) begin
			stepCnt_reg <= 3'h0;
			armed_reg   <= 1'b0;
		end else if (!armed_reg) begin
			if (stepCnt_reg == actSel_reg) begin
				armed_reg <= 1'b1;
			end else if (fullStep) begin
				stepCnt_reg <= stepCnt_reg + 3'h1;
			end
		end
	end

	// ************************************************************
	// System domain: flags, stop and status snapshot
	// ************************************************************
	logic stopped_reg;

	assign setAbs  = sampleStrobe && detectActive && absoluteThreshold != 4'h0 && bemfBelowAbs;
	assign setLow  = sampleStrobe && detectActive && deltaThreshold != 4'h0 && bemfBelowAvg;
	assign setHigh = sampleStrobe && detectActive && deltaThreshold != 4'h0 && bemfAboveAvg;
	assign anySet  = setAbs || setLow || setHigh;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			absStallFlag   <= 1'b0;
			delLowFlag     <= 1'b0;
			delHighFlag    <= 1'b0;
			stallFlag      <= 1'b0;
			stepLossFlag   <= 1'b0;
			stopped_reg    <= 1'b0;
			positionAccept <= 1'b1;
			hardStop       <= 1'b0;
			actualPosition <= 16'h0000;
			statusSnap_reg <= 8'h00;
			stAckTgl_reg   <= 1'b0;
		end else begin
			absStallFlag   <= setAbs || (absStallFlag && !stReqEdge);
			delLowFlag     <= setLow || (delLowFlag && !stReqEdge);
			delHighFlag    <= setHigh || (delHighFlag && !stReqEdge);
			stallFlag      <= anySet || ((absStallFlag || delLowFlag || delHighFlag) && !stReqEdge);
			stepLossFlag   <= (anySet && positioning) || (stepLossFlag && !stReqEdge);
			stopped_reg    <= (anySet && positioning) || (stopped_reg && !stReqEdge);
			positionAccept <= !((anySet && positioning) || (stopped_reg && !stReqEdge));
			hardStop       <= anySet && positioning;
			if (!stopped_reg || anySet) begin
				actualPosition <= internalPos;
			end
			if (stReqEdge) begin
				statusSnap_reg <= 8'h00;
				statusSnap_reg[sdc_pkg::ST_DEL_HIGH]  <= delHighFlag;
				statusSnap_reg[sdc_pkg::ST_DEL_LOW]   <= delLowFlag;
				statusSnap_reg[sdc_pkg::ST_ABS]       <= absStallFlag;
				statusSnap_reg[sdc_pkg::ST_STALL]     <= stallFlag;
				statusSnap_reg[sdc_pkg::ST_STEP_LOSS] <= stepLossFlag;
				statusSnap_reg[sdc_pkg::ST_MQ]        <= mq_reg;
				stAckTgl_reg <= ~stAckTgl_reg;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_stall_or: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stallFlag == (absStallFlag || delLowFlag || delHighFlag)) else $error("stall not OR");
	a_flags_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stReqEdge && !anySet |=> !stallFlag && !stepLossFlag) else $error("flags not cleared");
	a_md_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!mdEnabled |=> !sampleStrobe) else $error("sample while disabled");
	a_mq_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mq_reg |=> mq_reg && swiAnalogEn) else $error("qualify mode lost");
	a_switch_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mq_reg |=> $stable(switchState)) else $error("switch sampled in qualify");
	a_hard_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		anySet && positioning |=> hardStop && stepLossFlag && !positionAccept
		##1 !hardStop) else $error("stall stop wrong");
	a_full_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sampleStrobe && dutyFull && !dutyEn_reg && !stallFlag && !stReqEdge |=> !stallFlag)
		else $error("stall at full duty");
	a_not_armed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!accelDone |=> !armed_reg) else $error("armed before ramp end");
	a_thr_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmdEdge && cmdWord_reg[23:16] == sdc_pkg::CMD_SET_STALL |=>
		absoluteThreshold == $past(cmdWord_reg[15:12])) else $error("threshold not written");
	a_delay_min: assert property (@(posedge clk_sys) disable iff (sys_rst)
		zeroCross && mdEnabled |=> !sampleStrobe [*8]) else $error("sample too early");

endmodule

// [verif/sdc_i2c_master.sv]
// Purpose: Behavioural two-wire bus master facing the device
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes:   Bit period 2.7 us (about 370 kb/s); waits for a stretched clock

module sdc_i2c_master (
	// Resolved lines
	input  wire logic sclBus,
	input  wire logic sdaBus,
	// Pull-down enables
	output logic      sclDrv,
	output logic      sdaDrv
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int Q = 1250;
	int stuck = 0;
	initial begin
		sclDrv = 1'b0;
		sdaDrv = 1'b0;
	end
	task automatic sclHigh();
		int n;
		sclDrv = 1'b0;
		for (n = 0; n < 5000 && sclBus !== 1'b1; n++) #10;
		if (sclBus !== 1'b1) stuck++;
		#Q;
	endtask
	task automatic bitX(input logic v, output logic r);
		sdaDrv = !v;
		#Q;
		sclHigh();
		r = sdaBus;
		sclDrv = 1'b1;
		#200;
	endtask
	task automatic start();
		sdaDrv = 1'b0;
		#Q;
		sclHigh();
		sdaDrv = 1'b1;
		#Q;
		sclDrv = 1'b1;
		#200;
	endtask
	task automatic stop();
		sdaDrv = 1'b1;
		#Q;
		sclHigh();
		sdaDrv = 1'b0;
		#Q;
	endtask
	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitX(b[i], r);
		bitX(1'b1, r);
		ack = !r;
	endtask
	task automatic rdByte(input logic ackIt, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bitX(1'b1, b[i]);
		bitX(!ackIt, r);
	endtask
endmodule

// [verif/test_stall_detection_control.sv]
// Purpose: Self-checking bench for the stall detection control block
// Assumes: Short sample delay parameters for simulation
// Notes:   Bus traffic comes from the master model
module test_stall_detection_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int B = 20;
	localparam int S = 10;
	logic clk_sys = 0, clk_link = 0, sys_rst = 1, zeroCross = 0, accelDone = 0, fullStep = 0;
	logic dutyFull = 0, positioning = 0, bemfBelowAbs = 0, bemfBelowAvg = 0, bemfAboveAvg = 0;
	logic switchPin = 0, mScl, mSda, sclOe, sdaOe, sampleStrobe, hardStop, positionAccept;
	logic stepLossFlag, stallFlag, absStallFlag, delLowFlag, delHighFlag, switchState, swiAnalogEn;
	logic [15:0] internalPos = 16'h1234, actualPosition;
	logic [3:0] absoluteThreshold, deltaThreshold;
	logic [12:0] absLevelMv;
	logic [11:0] deltaLevelMv;
	int miscompares = 0, checks = 0, stops = 0;
	wire sclBus = !(mScl || sclOe);
	wire sdaBus = !(mSda || sdaOe);
	always #20 clk_sys = !clk_sys;
	initial begin
		#7;
		forever #16 clk_link = !clk_link;
	end
	always @(posedge clk_sys) if (hardStop === 1'b1) stops++;
	sdc_i2c_master m (.sclBus(sclBus), .sdaBus(sdaBus), .sclDrv(mScl), .sdaDrv(mSda));
	sdc_stall_detection_control #(.SAMPLE_BASE_CYC(B), .SAMPLE_STEP_CYC(S))
	sdc_stall_detection_control_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
		.sclIn(sclBus), .sclOut(), .sclOe(sclOe), .sdaIn(sdaBus), .sdaOut(), .sdaOe(sdaOe),
		.zeroCross(zeroCross), .accelDone(accelDone), .fullStep(fullStep), .dutyFull(dutyFull),
		.positioning(positioning), .internalPos(internalPos), .bemfBelowAbs(bemfBelowAbs),
		.bemfBelowAvg(bemfBelowAvg), .bemfAboveAvg(bemfAboveAvg), .switchPin(switchPin),
		.absoluteThreshold(absoluteThreshold), .deltaThreshold(deltaThreshold),
		.absLevelMv(absLevelMv), .deltaLevelMv(deltaLevelMv), .sampleStrobe(sampleStrobe),
		.hardStop(hardStop), .positionAccept(positionAccept), .actualPosition(actualPosition),
		.stepLossFlag(stepLossFlag), .stallFlag(stallFlag), .absStallFlag(absStallFlag),
		.delLowFlag(delLowFlag), .delHighFlag(delHighFlag), .switchState(switchState),
		.swiAnalogEn(swiAnalogEn));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] p1, input logic [7:0] p2);
		logic a;
		m.start();
		m.wrByte({sdc_pkg::DEV_ADDR, 1'b0}, a);
		check(a, 1, "addr ack");
		m.wrByte(c, a);
		m.wrByte(p1, a);
		m.wrByte(p2, a);
		m.stop();
		check(m.stuck, 0, "bus hang");
		if (m.stuck != 0) final_report();
		cyc(10);
	endtask
	task automatic status(input logic [7:0] exp);
		logic a;
		logic [7:0] b;
		m.start();
		m.wrByte({sdc_pkg::DEV_ADDR, 1'b1}, a);
		m.rdByte(1'b0, b);
		m.stop();
		check(m.stuck, 0, "bus hang");
		if (m.stuck != 0) final_report();
		check(b, exp, "status byte");
		cyc(10);
	endtask
	task automatic strobe(input int exp);
		int n;
		zeroCross = 1;
		for (n = 1; n <= 200; n++) begin
			@(negedge clk_sys);
			zeroCross = 0;
			if (sampleStrobe === 1'b1) break;
		end
		check(n, exp, "sample delay");
		if (n > 200 && exp <= 200) final_report();
		cyc(3);
	endtask
	task automatic t_reset();
		logic a;
		check(absoluteThreshold, 0, "abs reset");
		check(positionAccept, 1, "accept reset");
		m.start();
		m.wrByte({7'h61, 1'b0}, a);
		m.stop();
		check(a, 0, "foreign addr");
		cmd(sdc_pkg::CMD_SET_STALL, 8'h53, 8'h51);
		check(absoluteThreshold, 5, "abs set");
		check(deltaThreshold, 3, "del set");
		check(absLevelMv, 2500, "abs level");
		check(deltaLevelMv, 750, "del level");
		$display("test reset_params done");
	endtask
	task automatic t_stall();
		positioning = 1;
		accelDone = 1;
		bemfBelowAbs = 1;
		cyc(2);
		strobe(B + S + 1);
		check(stallFlag, 0, "armed early");
		repeat (2) begin
			fullStep = 1;
			cyc(1);
			fullStep = 0;
			cyc(1);
		end
		strobe(B + S + 1);
		check({absStallFlag, stallFlag, stepLossFlag}, 3'h7, "stall flags");
		check({positionAccept, actualPosition}, 17'h01234, "stop copy");
		check(stops, 1, "hard stop");
		internalPos = 16'h4321;
		cyc(2);
		check(actualPosition, 16'h1234, "frozen");
		status(8'h1c);
		check({stallFlag, positionAccept}, 2'h1, "cleared");
		check(actualPosition, 16'h4321, "resumed");
		status(8'h00);
		$display("test stall done");
	endtask
	task automatic t_duty();
		bemfBelowAbs = 0;
		bemfBelowAvg = 1;
		dutyFull = 1;
		cmd(sdc_pkg::CMD_SET_STALL, 8'h53, 8'h00);
		strobe(B + 1);
		check(delLowFlag, 0, "full duty");
		dutyFull = 0;
		strobe(B + 1);
		check(delLowFlag, 1, "duty low");
		status(8'h1a);
		bemfBelowAvg = 0;
		bemfAboveAvg = 1;
		strobe(B + 1);
		check(delHighFlag, 1, "delta high");
		status(8'h19);
		cmd(sdc_pkg::CMD_SET_STALL, 8'h00, 8'h00);
		strobe(201);
		$display("test duty_off done");
	endtask
	task automatic t_mq();
		switchPin = 1;
		cyc(4);
		check(switchState, 1, "switch");
		cmd(sdc_pkg::CMD_MOTION_QUALIFY, 8'h00, 8'h00);
		check(swiAnalogEn, 1, "analog");
		switchPin = 0;
		cyc(4);
		check(switchState, 1, "frozen switch");
		cmd(sdc_pkg::CMD_SET_NV, 8'h21, 8'h00);
		check(swiAnalogEn, 1, "mode kept");
		status(8'h20);
		sys_rst = 1;
		cyc(5);
		sys_rst = 0;
		cyc(10);
		check({absoluteThreshold, deltaThreshold}, 8'h21, "load copies");
		check(swiAnalogEn, 0, "mode reset");
		$display("test qualify_nv done");
	endtask
	initial begin
		cyc(5);
		sys_rst = 0;
		cyc(10);
		t_reset();
		t_stall();
		t_duty();
		t_mq();
		final_report();
	end
endmodule
